// ===== cxio_defs.svh
// constants for the channel external control block
// How it works
// - a rising external trigger starts the channel's voltage and current ramps
// - any output change holds the sync pulse high until 10 ms after the latest change, then low
// - fault indicator is high during a supply fault, low otherwise
// - output enabled while the on/off request is high, disabled while low
// - mode indicator low in constant voltage, high in constant current
`ifndef CXIO_DEFS_SVH
`define CXIO_DEFS_SVH

`define CXIO_CLK_MHZ        200
`define CXIO_SYNC_PULSE_MS  10
// cycles of the sync pulse: ms * MHz * 1000
`define CXIO_SYNC_CYCLES    (`CXIO_SYNC_PULSE_MS * `CXIO_CLK_MHZ * 1000)
`define CXIO_CNT_W          21
`define CXIO_CNT_ZERO       21'h000000
`define CXIO_SYNC_RST       2'h0

`endif

// ===== cxio_pkg.sv
// types for the channel external control block
`include "cxio_defs.svh"
package cxio_pkg;
    typedef logic [`CXIO_CNT_W-1:0] cxio_cnt_t;
    typedef enum logic {CXIO_IDLE, CXIO_PULSE} cxio_state_t;
endpackage

// ===== cxio_sync2.sv
// two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
module cxio_sync2 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // the first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'h0;
            q      <= 1'h0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ===== cxio_ctrl.sv
// channel external control: trigger, on/off, fault, mode and sync pulse
`timescale 1ns/100ps
`include "cxio_defs.svh"
module cxio_ctrl (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ext_ramp_trigger_in,
    input  wire logic output_enable_request_in,
    input  wire logic supply_fault,
    input  wire logic constant_current_regulation,
    input  wire logic output_changed,
    output logic      ramp_start,
    output logic      output_enable,
    output logic      fault_indicator_out,
    output logic      regulation_mode_out,
    output logic      change_sync_pulse_out
);
    import cxio_pkg::*;

    localparam cxio_cnt_t SYNC_LAST = cxio_cnt_t'(`CXIO_SYNC_CYCLES - 1);

    // one increment shared by the pulse timer and the length monitor
    function automatic cxio_cnt_t cnt_inc(input cxio_cnt_t c);
        return c + 1'b1;
    endfunction

    logic        trig_s;
    logic        onoff_s;
    logic        trig_prev_q;
    logic        en_prev_q;
    cxio_state_t state_q;
    cxio_state_t state_d;
    cxio_cnt_t   cnt_q;
    cxio_cnt_t   cnt_d;
    wire         trig_rise;
    wire         en_change;
    wire         change_evt;
    wire         cnt_last;
    wire         pulse_next;

    // both connector inputs are asynchronous to clk
    cxio_sync2 u_trig_sync (
        .clk (clk),
        .rst (rst),
        .d   (ext_ramp_trigger_in),
        .q   (trig_s)
    );
    cxio_sync2 u_onoff_sync (
        .clk (clk),
        .rst (rst),
        .d   (output_enable_request_in),
        .q   (onoff_s)
    );

    // edge detect on synchronised levels only
    assign trig_rise  = trig_s & ~trig_prev_q;
    assign en_change  = onoff_s ^ en_prev_q;
    // the request pin and the ramp engine both count as output changes
    assign change_evt = en_change | output_changed;
    // timer decode kept as named wires so the processes stay short
    assign cnt_last   = (cnt_q == SYNC_LAST);
    assign pulse_next = (state_d == CXIO_PULSE);

    // registered outputs and edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_prev_q         <= 1'h0;
            en_prev_q           <= 1'h0;
            ramp_start          <= 1'h0;
            output_enable       <= 1'h0;
            fault_indicator_out <= 1'h0;
            regulation_mode_out <= 1'h0;
        end else begin
            trig_prev_q         <= trig_s;
            en_prev_q           <= onoff_s;
            ramp_start          <= trig_rise;
            output_enable       <= onoff_s;
            fault_indicator_out <= supply_fault;
            regulation_mode_out <= constant_current_regulation;
        end
    end

    // pulse timer; a new change mid-pulse restarts the full 10 ms
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            CXIO_IDLE: begin
                if (change_evt) begin
                    state_d = CXIO_PULSE;
                    cnt_d   = `CXIO_CNT_ZERO;
                end
            end
            CXIO_PULSE: begin
                if (change_evt) begin
                    cnt_d = `CXIO_CNT_ZERO;
                end else if (cnt_last) begin
                    state_d = CXIO_IDLE;
                end else begin
                    cnt_d = cnt_inc(cnt_q);
                end
            end
            default: state_d = CXIO_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q               <= CXIO_IDLE;
            cnt_q                 <= `CXIO_CNT_ZERO;
            change_sync_pulse_out <= 1'h0;
        end else begin
            state_q               <= state_d;
            cnt_q                 <= cnt_d;
            change_sync_pulse_out <= pulse_next;
        end
    end

    // length monitor: cycles since the last change while the pulse stands
    // a change clears it, so a stretched pulse is measured from its last restart
    cxio_cnt_t hi_len_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_len_q <= `CXIO_CNT_ZERO;
        end else if (change_evt) begin
            hi_len_q <= `CXIO_CNT_ZERO;
        end else if (change_sync_pulse_out) begin
            hi_len_q <= cnt_inc(hi_len_q);
        end else begin
            hi_len_q <= `CXIO_CNT_ZERO;
        end
    end

    // sync pulse steps: a change, then the pulse one edge later
    sequence s_change;
        change_evt;
    endsequence
    sequence s_pulse_up;
        ##1 change_sync_pulse_out;
    endsequence
    // pulse still counting towards its last cycle
    sequence s_pulse_running;
        change_sync_pulse_out && !cnt_last;
    endsequence
    // pulse quiet and nothing asks for it
    sequence s_pulse_quiet;
        !change_sync_pulse_out && !change_evt;
    endsequence
    // trigger level seen high on two edges in a row
    sequence s_trig_held;
        trig_s && $past(trig_s);
    endsequence

    // sync pulse: start, stand, end and length
    // the 10 ms end is far beyond a short run; these guard it by counting
    a_sync_pulse_start: assert property (@(posedge clk) disable iff (rst)
        s_change |-> s_pulse_up)
        else $error("sync pulse did not start after change");
    a_sync_hold: assert property (@(posedge clk) disable iff (rst)
        s_pulse_running |=> change_sync_pulse_out)
        else $error("sync pulse dropped before 10 ms");
    a_sync_quiet: assert property (@(posedge clk) disable iff (rst)
        s_pulse_quiet |=> !change_sync_pulse_out)
        else $error("sync pulse without an output change");
    a_sync_pulse_len: assert property (@(posedge clk) disable iff (rst)
        (hi_len_q <= SYNC_LAST + 1'b1))
        else $error("sync pulse longer than 10 ms");
    // restarts are excluded: the monitor measures from the last change
    a_sync_exact: assert property (@(posedge clk) disable iff (rst)
        $fell(change_sync_pulse_out) |-> (hi_len_q == SYNC_LAST + 1'b1))
        else $error("sync pulse not exactly 10 ms");
    a_sync_pulse_end: assert property (@(posedge clk) disable iff (rst)
        (state_q == CXIO_PULSE && cnt_q == SYNC_LAST && !change_evt)
        |=> !change_sync_pulse_out)
        else $error("sync pulse did not end");
    // an on/off edge after the two flops is itself an output change
    a_change_pulse: assert property (@(posedge clk) disable iff (rst)
        $changed(onoff_s) |=> change_sync_pulse_out)
        else $error("sync pulse missing after request change");

    // trigger: one start per rising level, none while it stays high
    // a trigger held high across many cycles must not restart the ramps
    a_trig_start: assert property (@(posedge clk) disable iff (rst)
        $rose(trig_s) |=> ramp_start)
        else $error("trigger did not start ramp");
    a_trig_once: assert property (@(posedge clk) disable iff (rst)
        ramp_start |=> !ramp_start)
        else $error("ramp start longer than one cycle");
    a_trig_held: assert property (@(posedge clk) disable iff (rst)
        s_trig_held |=> !ramp_start)
        else $error("ramp start while trigger held");
    a_trig_spur: assert property (@(posedge clk) disable iff (rst)
        !$rose(trig_s) |=> !ramp_start)
        else $error("ramp start without trigger edge");

    // request path: two flops in, one register out
    // the pin is only looked at on clock edges, two edges behind at the flop output
    a_onoff_follow: assert property (@(posedge clk) disable iff (rst)
        ##1 output_enable == $past(onoff_s))
        else $error("output enable does not follow request");
    a_input_sync: assert property (@(posedge clk) disable iff (rst)
        ##2 (onoff_s == $past(output_enable_request_in, 2)))
        else $error("request not through two flops");
    a_trig_sync: assert property (@(posedge clk) disable iff (rst)
        ##2 (trig_s == $past(ext_ramp_trigger_in, 2)))
        else $error("trigger not through two flops");

    // status levels follow their sources one edge later
    // same-clock sources, so no synchroniser delay here
    a_fault_follow: assert property (@(posedge clk) disable iff (rst)
        supply_fault |=> fault_indicator_out)
        else $error("fault indicator low during fault");
    a_fault_clear: assert property (@(posedge clk) disable iff (rst)
        !supply_fault |=> !fault_indicator_out)
        else $error("fault indicator high without fault");
    a_mode_follow: assert property (@(posedge clk) disable iff (rst)
        !constant_current_regulation |=> !regulation_mode_out)
        else $error("mode indicator high in constant voltage");
    a_mode_cc: assert property (@(posedge clk) disable iff (rst)
        constant_current_regulation |=> regulation_mode_out)
        else $error("mode indicator low in constant current");
endmodule

// ===== cxio_ext_model.sv
// outside controller model driving the two connector input pins
`timescale 1ns/100ps
module cxio_ext_model (
    input  wire logic trig_cmd,
    input  wire logic req_cmd,
    output logic      trig_pin,
    output logic      req_pin
);
    // pins move off the clock grid, as a truly asynchronous source would
    assign #1.3 trig_pin = trig_cmd;
    assign #1.3 req_pin  = req_cmd;
endmodule

// ===== tb_top.sv
// self-checking bench for the channel external control block
`timescale 1ns/100ps
module tb_top;
    logic       clk = 0, rst = 1, trig_cmd = 0, req_cmd = 0;
    logic       flt = 0, cc = 0, chg = 0;
    logic       trig_pin, req_pin, rs, oe, fo, mo, sp;
    logic [4:0] v;
    logic [4:0] note_q[$];
    int         n_mismatch = 0, total_checks = 0, seed = 42;
    event       seen_ev;

    // 200 MHz clock
    initial forever #2.5 clk = ~clk;

    cxio_ext_model ext (.trig_cmd(trig_cmd), .req_cmd(req_cmd),
        .trig_pin(trig_pin), .req_pin(req_pin));
    cxio_ctrl dut (.clk(clk), .rst(rst), .ext_ramp_trigger_in(trig_pin),
        .output_enable_request_in(req_pin), .supply_fault(flt),
        .constant_current_regulation(cc), .output_changed(chg),
        .ramp_start(rs), .output_enable(oe), .fault_indicator_out(fo),
        .regulation_mode_out(mo), .change_sync_pulse_out(sp));

    task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // inputs move 1 ns after the edge, so no race with the design's flops
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // driver side: note what the outputs {rs,oe,fo,mo,sp} should show now
    task automatic note(logic [4:0] e);
        note_q.push_back(e);
        -> seen_ev;
    endtask

    // watcher side: oldest note against the outputs
    always @(seen_ev) begin
        v = note_q.pop_front();
        check("ramp_enable", {rs, oe}, v[4:3]);
        check("fault_mode", {fo, mo}, v[2:1]);
        check("sync_pulse", {1'b0, sp}, {1'b0, v[0]});
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        step(10);
        note(5'h00);
        rst = 0;
        // random fault and regulation levels, one edge of latency
        repeat (8) begin
            flt = 1'($random(seed));
            cc = 1'($random(seed));
            step(1);
            note({2'b00, flt, cc, 1'b0});
        end
        $display("test fault_mode done");
        // trigger: start shows on the third edge, not before, and only once
        trig_cmd = 1;
        step(2);
        note({2'b00, flt, cc, 1'b0});
        step(1);
        note({2'b10, flt, cc, 1'b0});
        step(20);
        note({2'b00, flt, cc, 1'b0});
        trig_cmd = 0;
        $display("test trigger done");
        // on/off request: enable and sync pulse after the synchroniser
        req_cmd = 1;
        step(2);
        note({2'b00, flt, cc, 1'b0});
        step(1);
        note({2'b01, flt, cc, 1'b1});
        chg = 1;
        step(1);
        chg = 0;
        // the full 10 ms pulse is too long to watch; only its holding is seen
        step(100);
        note({2'b01, flt, cc, 1'b1});
        req_cmd = 0;
        step(4);
        note({2'b00, flt, cc, 1'b1});
        $display("test request done");
        // reset in mid-pulse clears every output at once
        rst = 1;
        step(1);
        note(5'h00);
        rst = 0;
        // levels come back one edge after release, the pulse stays down
        step(1);
        note({2'b00, flt, cc, 1'b0});
        step(1);
        note({2'b00, flt, cc, 1'b0});
        $display("test reset done");
        step(1);
        summarize();
    end
endmodule
